// ==== verilog/vic_pkg.sv ====
package vic_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_REQUEST = 8'h00;
  localparam logic [7:0] ADDR_ENABLE  = 8'h04;
  localparam logic [7:0] ADDR_MASTER  = 8'h08;
  localparam logic [7:0] ADDR_EDGESEL = 8'h0C;
  localparam logic [7:0] ADDR_VECTOR  = 8'h10;
  localparam logic [7:0] ADDR_IRQSTAT = 8'h14;
  localparam logic [7:0] ADDR_IRQMASK = 8'h18;
  localparam logic [7:0] ADDR_ACK     = 8'h1C;
  localparam int         ADDR_W       = 8;

  // ----------------------------------------------------------------
  // source bit positions in request and enable words
  // ----------------------------------------------------------------
  localparam int NSRC         = 8;
  localparam int SRC_TICK     = 0;
  localparam int SRC_DUALEDGE = 1;
  localparam int SRC_SELEDGE  = 2;
  localparam int SRC_SECOND   = 3;
  localparam int SRC_SERIAL   = 4;
  localparam int SRC_TIMER    = 5;
  localparam int SRC_EXTTEST  = 6;
  localparam int SRC_WATCH    = 7;

  // vector table addresses, slots 1 to 5
  localparam logic [15:0] VEC_SLOT_ONE   = 16'h0002;
  localparam logic [15:0] VEC_SLOT_TWO   = 16'h0004;
  localparam logic [15:0] VEC_SLOT_THREE = 16'h0006;
  localparam logic [15:0] VEC_SLOT_FOUR  = 16'h0008;
  localparam logic [15:0] VEC_SLOT_FIVE  = 16'h000A;
  localparam logic [2:0]  SLOT_NONE      = 3'h0;

  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // interrupt events for the sticky status word
  localparam int NEVT         = 2;
  localparam int EVT_TEST     = 0;
  localparam int EVT_PENDING  = 1;

  typedef struct packed {
    logic [NSRC-1:0] src;
  } vic_src_t;

endpackage : vic_pkg

// ==== verilog/vic_edge.sv ====
`timescale 1ns/1ns
// per-input edge detector with rise, fall or both selection
module vic_edge #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         nrst_i,
  input  wire logic [W-1:0] sig_i,
  input  wire logic [W-1:0] rise_en_i,
  input  wire logic [W-1:0] fall_en_i,
  output logic      [W-1:0] edge_o
);

  typedef struct packed {
    logic [W-1:0] prev;
    logic         primed;
  } vic_edge_state_t;

  vic_edge_state_t s_q;
  vic_edge_state_t s_d;

  // first cycle after reset only primes, so a static level is no edge
  always_comb
  begin
    s_d        = s_q;
    s_d.prev   = sig_i;
    s_d.primed = 1'b1;
  end

  for (genvar i = 0; i < W; i++)
  begin : g_bit
    assign edge_o[i] = s_q.primed &
                       ((rise_en_i[i] & sig_i[i] & ~s_q.prev[i]) |
                        (fall_en_i[i] & ~sig_i[i] & s_q.prev[i]));
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      s_q <= '0;
    else
      s_q <= s_d;
  end

endmodule : vic_edge

// ==== verilog/vic_top.sv ====
`timescale 1ns/1ns
// Function
// RULE_01 - simultaneous enabled requests are served lowest priority number first.
// RULE_02 - the interval tick request is priority 1 and vectors to 0002H.
// RULE_03 - the dual edge request fires on both edges and shares the 0002H vector.
// RULE_04 - the select edge request uses a chosen edge at 0004H; the second request uses 0006H.
// RULE_05 - the serial done event is priority 4 vectored to 0008H.
// RULE_06 - the timer match request, raised on count equal modulo, is priority 5 at 000AH.
// RULE_07 - the two test sources set and gate flags but never vector.
// RULE_08 - the test flag sets on a test pin rise or any key return fall.
// RULE_09 - a vectored request is taken only with its enable and the master enable set.
// RULE_10 - software can read every request flag without taking an interrupt.
// RULE_11 - standby is released only by requests whose enable is set.
// RULE_12 - the watch flag sets on each half second tick and can release standby.
// RULE_13 - the service start address comes from the taken source's vector entry.
// RULE_14 - nesting is allowed and software steers it with the enables.
// RULE_15 - vector entries lie at 0002H to 000BH, two bytes each.
// RULE_16 - reset clears all request flags, enables and the master enable.
// RULE_17 - acknowledge clears the taken flag, except where a vector is shared.
module vic_top (
  input  wire logic                     clk_i,
  input  wire logic                     nrst_i,
  // event sources
  input  wire logic                     interval_tick_i,
  input  wire logic                     dual_edge_ext_i,
  input  wire logic                     select_edge_ext_i,
  input  wire logic                     second_ext_i,
  input  wire logic                     serial_done_i,
  input  wire logic [7:0]               timer_count_i,
  input  wire logic [7:0]               timer_modulo_i,
  input  wire logic                     ext_test_pin_i,
  input  wire logic [7:0]               key_return_inputs_i,
  input  wire logic                     watch_half_sec_i,
  // cpu side
  input  wire logic                     cpu_ack_i,
  output logic                          irq_req_o,
  output logic [15:0]                   vector_addr_o,
  output logic                          standby_release_o,
  output logic                          irq_o,
  // axi4-lite slave
  input  wire logic [vic_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [vic_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready
);

  typedef struct packed {
    vic_pkg::vic_src_t          source_request_flag;
    vic_pkg::vic_src_t          source_enable_flag;
    logic                       master_irq_enable;
    logic                       select_edge_rising;
    logic                       timer_match_prev;
    logic [15:0]                vec_base;
    logic [vic_pkg::NEVT-1:0]   irq_stat;
    logic [vic_pkg::NEVT-1:0]   irq_mask;
    logic                       aw_held;
    logic [vic_pkg::ADDR_W-1:0] aw_addr;
    logic                       w_held;
    logic [31:0]                w_data;
    logic [3:0]                 w_strb;
    logic                       bvalid;
    logic [1:0]                 bresp;
    logic                       rvalid;
    logic [31:0]                rdata;
    logic [1:0]                 rresp;
    logic                       irq_req;
    logic [15:0]                vector_addr;
    logic                       standby_release;
  } vic_state_t;

  vic_state_t s_q;
  vic_state_t s_d;

  // ----------------------------------------------------------------
  // edge detection of external pins
  // ----------------------------------------------------------------
  localparam int NEDGE = 11;
  logic [NEDGE-1:0] edge_sig;
  logic [NEDGE-1:0] edge_rise;
  logic [NEDGE-1:0] edge_fall;
  logic [NEDGE-1:0] edge_hit;

  assign edge_sig  = {key_return_inputs_i, ext_test_pin_i, select_edge_ext_i, dual_edge_ext_i};
  assign edge_rise = {8'h00, 1'b1, s_q.select_edge_rising, 1'b1}; // RULE_08 RULE_04
  assign edge_fall = {8'hFF, 1'b0, ~s_q.select_edge_rising, 1'b1}; // RULE_03 RULE_08

  vic_edge #(
    .W(NEDGE)
  ) u_edge (
    .clk_i     (clk_i),
    .nrst_i    (nrst_i),
    .sig_i     (edge_sig),
    .rise_en_i (edge_rise),
    .fall_en_i (edge_fall),
    .edge_o    (edge_hit)
  );

  // second request is a level pulse from its own edge logic outside
  logic                     timer_match;
  logic [vic_pkg::NSRC-1:0] raise;
  logic [vic_pkg::NSRC-1:0] pend;
  logic [2:0]               slot;
  logic [15:0]              slot_addr;

  assign timer_match = (timer_count_i == timer_modulo_i); // RULE_06

  always_comb
  begin
    raise = '0;
    raise[vic_pkg::SRC_TICK]     = interval_tick_i; // RULE_02
    raise[vic_pkg::SRC_DUALEDGE] = edge_hit[0]; // RULE_03
    raise[vic_pkg::SRC_SELEDGE]  = edge_hit[1]; // RULE_04
    raise[vic_pkg::SRC_SECOND]   = second_ext_i; // RULE_04
    raise[vic_pkg::SRC_SERIAL]   = serial_done_i; // RULE_05
    raise[vic_pkg::SRC_TIMER]    = timer_match & ~s_q.timer_match_prev; // RULE_06
    raise[vic_pkg::SRC_EXTTEST]  = |edge_hit[NEDGE-1:2]; // RULE_08
    raise[vic_pkg::SRC_WATCH]    = watch_half_sec_i; // RULE_12
  end

  // enabled pending requests; test sources gated but never vectored
  assign pend = s_q.source_request_flag.src & s_q.source_enable_flag.src; // RULE_09 RULE_07

  // ----------------------------------------------------------------
  // fixed priority resolution
  // ----------------------------------------------------------------
  always_comb
  begin
    slot      = vic_pkg::SLOT_NONE;
    slot_addr = vic_pkg::VEC_SLOT_ONE;
    if (pend[vic_pkg::SRC_TICK] | pend[vic_pkg::SRC_DUALEDGE]) // RULE_01 RULE_03
    begin
      slot      = 3'h1;
      slot_addr = vic_pkg::VEC_SLOT_ONE; // RULE_02
    end
    else if (pend[vic_pkg::SRC_SELEDGE])
    begin
      slot      = 3'h2;
      slot_addr = vic_pkg::VEC_SLOT_TWO; // RULE_04
    end
    else if (pend[vic_pkg::SRC_SECOND])
    begin
      slot      = 3'h3;
      slot_addr = vic_pkg::VEC_SLOT_THREE; // RULE_04
    end
    else if (pend[vic_pkg::SRC_SERIAL])
    begin
      slot      = 3'h4;
      slot_addr = vic_pkg::VEC_SLOT_FOUR; // RULE_05
    end
    else if (pend[vic_pkg::SRC_TIMER])
    begin
      slot      = 3'h5;
      slot_addr = vic_pkg::VEC_SLOT_FIVE; // RULE_06
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic                     aw_take;
  logic                     w_take;
  logic                     ar_take;
  logic                     wr_go;
  logic                     ack_clr;
  logic [vic_pkg::NSRC-1:0] sw_clr;
  logic [vic_pkg::NSRC-1:0] ack_mask;
  logic [31:0]              rd_word;
  logic                     rd_ok;
  logic                     wr_ok;
  logic [vic_pkg::NEVT-1:0] evt;

  assign s_axi_awready = ~s_q.aw_held & ~s_q.bvalid;
  assign s_axi_wready  = ~s_q.w_held & ~s_q.bvalid;
  assign s_axi_arready = ~s_q.rvalid;
  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take  = s_axi_wvalid & s_axi_wready;
  assign ar_take = s_axi_arvalid & s_axi_arready;
  assign wr_go   = s_q.aw_held & s_q.w_held;

  assign ack_clr = cpu_ack_i & s_q.irq_req;

  always_comb
  begin
    ack_mask = '0;
    // shared slot one: both flags are left to software
    unique case (slot)
      3'h2: ack_mask[vic_pkg::SRC_SELEDGE] = ack_clr; // RULE_17
      3'h3: ack_mask[vic_pkg::SRC_SECOND]  = ack_clr; // RULE_17
      3'h4: ack_mask[vic_pkg::SRC_SERIAL]  = ack_clr; // RULE_17
      3'h5: ack_mask[vic_pkg::SRC_TIMER]   = ack_clr; // RULE_17
      default: ack_mask = '0;
    endcase
  end

  always_comb
  begin
    rd_ok = 1'b1;
    unique case (s_axi_araddr)
      vic_pkg::ADDR_REQUEST: rd_word = {24'h000000, s_q.source_request_flag.src}; // RULE_10
      vic_pkg::ADDR_ENABLE:  rd_word = {24'h000000, s_q.source_enable_flag.src};
      vic_pkg::ADDR_MASTER:  rd_word = {31'h00000000, s_q.master_irq_enable};
      vic_pkg::ADDR_EDGESEL: rd_word = {31'h00000000, s_q.select_edge_rising};
      vic_pkg::ADDR_VECTOR:  rd_word = {16'h0000, s_q.vec_base};
      vic_pkg::ADDR_IRQSTAT: rd_word = {30'h00000000, s_q.irq_stat};
      vic_pkg::ADDR_IRQMASK: rd_word = {30'h00000000, s_q.irq_mask};
      default:
      begin
        rd_word = 32'h00000000;
        rd_ok   = 1'b0;
      end
    endcase
  end

  always_comb
  begin
    wr_ok  = 1'b1;
    sw_clr = '0;
    s_d    = s_q;
    evt[vic_pkg::EVT_TEST]    = raise[vic_pkg::SRC_EXTTEST] | raise[vic_pkg::SRC_WATCH];
    evt[vic_pkg::EVT_PENDING] = |raise[vic_pkg::SRC_TIMER:vic_pkg::SRC_TICK];

    s_d.timer_match_prev = timer_match;

    if (aw_take)
    begin
      s_d.aw_held = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (w_take)
    begin
      s_d.w_held = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end

    // software writes; byte lane 0 carries every field but the vector base
    if (wr_go)
    begin
      s_d.aw_held = 1'b0;
      s_d.w_held  = 1'b0;
      s_d.bvalid  = 1'b1;
      unique case (s_q.aw_addr)
        vic_pkg::ADDR_REQUEST:
          if (s_q.w_strb[0]) sw_clr = ~s_q.w_data[7:0];
        vic_pkg::ADDR_ENABLE:
          if (s_q.w_strb[0]) s_d.source_enable_flag.src = s_q.w_data[7:0]; // RULE_14
        vic_pkg::ADDR_MASTER:
          if (s_q.w_strb[0]) s_d.master_irq_enable = s_q.w_data[0]; // RULE_14
        vic_pkg::ADDR_EDGESEL:
          if (s_q.w_strb[0]) s_d.select_edge_rising = s_q.w_data[0]; // RULE_04
        vic_pkg::ADDR_VECTOR:
        begin
          if (s_q.w_strb[0]) s_d.vec_base[7:0]  = s_q.w_data[7:0]; // RULE_13
          if (s_q.w_strb[1]) s_d.vec_base[15:8] = s_q.w_data[15:8];
        end
        vic_pkg::ADDR_IRQMASK:
          if (s_q.w_strb[0]) s_d.irq_mask = s_q.w_data[vic_pkg::NEVT-1:0];
        vic_pkg::ADDR_ACK, vic_pkg::ADDR_IRQSTAT: ;
        default: wr_ok = 1'b0;
      endcase
      s_d.bresp = wr_ok ? vic_pkg::RESP_OKAY : vic_pkg::RESP_SLVERR;
    end
    if (s_q.bvalid & s_axi_bready)
      s_d.bvalid = 1'b0;

    // request flags: a new event wins over any clear in the same cycle
    s_d.source_request_flag.src = (s_q.source_request_flag.src & ~sw_clr & ~ack_mask)
                                  | raise; // RULE_17 RULE_07

    // sticky status, cleared by a read, set wins over the clear
    if (ar_take)
    begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = rd_word;
      s_d.rresp  = rd_ok ? vic_pkg::RESP_OKAY : vic_pkg::RESP_SLVERR;
      if (s_axi_araddr == vic_pkg::ADDR_IRQSTAT)
        s_d.irq_stat = '0;
    end
    if (s_q.rvalid & s_axi_rready)
      s_d.rvalid = 1'b0;
    s_d.irq_stat = s_d.irq_stat | evt;

    // vectored request to the cpu; dropped on ack so nesting is software's choice
    s_d.irq_req     = s_q.master_irq_enable & (slot != vic_pkg::SLOT_NONE) & ~ack_clr; // RULE_09 RULE_14
    s_d.vector_addr = s_q.vec_base + slot_addr; // RULE_13 RULE_15
    // release ignores the master enable, as in standby the cpu cannot act
    s_d.standby_release = |pend; // RULE_11 RULE_12
  end

  // ----------------------------------------------------------------
  // registers and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      s_q <= '0; // RULE_16
    else
      s_q <= s_d;
  end

  assign irq_req_o         = s_q.irq_req;
  assign vector_addr_o     = s_q.vector_addr;
  assign standby_release_o = s_q.standby_release;
  assign irq_o             = |(s_q.irq_stat & s_q.irq_mask);
  assign s_axi_bvalid      = s_q.bvalid;
  assign s_axi_bresp       = s_q.bresp;
  assign s_axi_rvalid      = s_q.rvalid;
  assign s_axi_rdata       = s_q.rdata;
  assign s_axi_rresp       = s_q.rresp;

endmodule : vic_top

// ==== verification/vic_top_asserts.sv ====
`timescale 1ns/1ns
module vic_top_asserts (
  input wire logic                       clk_i,
  input wire logic                       nrst_i,
  input wire logic                       cpu_ack_i,
  input wire logic                       irq_req_o,
  input wire logic                       standby_release_o,
  input wire logic                       irq_o,
  input wire logic                       s_axi_awvalid,
  input wire logic                       s_axi_awready,
  input wire logic                       s_axi_wvalid,
  input wire logic                       s_axi_wready,
  input wire logic [1:0]                 s_axi_bresp,
  input wire logic                       s_axi_bvalid,
  input wire logic                       s_axi_bready,
  input wire logic [vic_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic                       s_axi_arvalid,
  input wire logic                       s_axi_arready,
  input wire logic [31:0]                s_axi_rdata,
  input wire logic [1:0]                 s_axi_rresp,
  input wire logic                       s_axi_rvalid,
  input wire logic                       s_axi_rready
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  // ----------------------------------------
  // bus handshakes
  // ----------------------------------------
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  wr_answer_a: assert property (wr_taken |-> ##2 s_axi_bvalid)
    else $error("write response late");
  rd_answer_a: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read response late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  one_read_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while answering");
  bad_read_a: assert property (rd_taken ##0 (s_axi_araddr > vic_pkg::ADDR_ACK) |=>
    s_axi_rresp == vic_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");

  // ----------------------------------------
  // cpu side
  // ----------------------------------------
  ack_drop_a: assert property (cpu_ack_i && irq_req_o |=> !irq_req_o)
    else $error("request stands after acknowledge");
  // the first edge in reset only loads the cleared state, so look from the second one on
  reset_quiet_a: assert property (disable iff (1'b0)
    !nrst_i ##1 !nrst_i |->
    !irq_req_o && !irq_o && !standby_release_o && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs active in reset");
endmodule : vic_top_asserts

// ==== verification/vic_cpu_model.sv ====
`timescale 1ns/1ns
module vic_cpu_model (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic irq_req_i,
  input  wire logic go_i,
  input  wire logic slow_i,
  output logic      cpu_ack_o
);
  logic [1:0] wait_q;

  // ----------------------------------------
  // acknowledge after 1 or 4 request cycles
  // ----------------------------------------
  // master stays set, so a slow cpu models nesting under software control
  always_ff @(posedge clk_i or negedge nrst_i)
    if (!nrst_i)
    begin
      wait_q    <= 2'h0;
      cpu_ack_o <= 1'b0;
    end
    else
    begin
      cpu_ack_o <= 1'b0;
      if (!irq_req_i || cpu_ack_o || !go_i)
        wait_q <= 2'h0;
      else if (wait_q == (slow_i ? 2'h3 : 2'h0))
        cpu_ack_o <= 1'b1;
      else
        wait_q <= wait_q + 2'h1;
    end
endmodule : vic_cpu_model

// ==== verification/vic_top_tb.sv ====
`timescale 1ns/1ns
module vic_top_tb;
  logic clk_i = 1'b0, nrst_i = 1'b0, cpu_ack_i, cpu_go = 1'b0, cpu_slow = 1'b0;
  logic interval_tick_i = 1'b0, dual_edge_ext_i = 1'b0, select_edge_ext_i = 1'b0;
  logic second_ext_i = 1'b0, serial_done_i = 1'b0, ext_test_pin_i = 1'b0;
  logic watch_half_sec_i = 1'b0;
  logic [7:0] timer_count_i = 8'h00, timer_modulo_i = 8'h10, key_return_inputs_i = 8'hFF;
  logic irq_req_o, standby_release_o, irq_o;
  logic [15:0] vector_addr_o;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] exp_vec [4] = '{16'h0104, 16'h0106, 16'h0108, 16'h010A};
  int n_mismatch = 0, cmp_count = 0;

  always #5 clk_i = ~clk_i;

  vic_top i_dut (.clk_i, .nrst_i, .interval_tick_i, .dual_edge_ext_i, .select_edge_ext_i,
    .second_ext_i, .serial_done_i, .timer_count_i, .timer_modulo_i, .ext_test_pin_i,
    .key_return_inputs_i, .watch_half_sec_i, .cpu_ack_i, .irq_req_o, .vector_addr_o,
    .standby_release_o, .irq_o, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  vic_cpu_model i_cpu (.clk_i, .nrst_i, .irq_req_i(irq_req_o), .go_i(cpu_go),
    .slow_i(cpu_slow), .cpu_ack_o(cpu_ack_i));

  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      $display("unexpected %s expected %h seen %h", n, e, g);
      n_mismatch++;
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick

  // bready is raised only once bvalid is seen, so the slave must hold its answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = vic_pkg::RESP_OKAY);
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    while (pa || pw)
    begin
      @(posedge clk_i);
      if (pa && s_axi_awready)
      begin
        s_axi_awvalid <= 1'b0;
        pa = 1'b0;
      end
      if (pw && s_axi_wready)
      begin
        s_axi_wvalid <= 1'b0;
        pw = 1'b0;
      end
    end
    while (!s_axi_bvalid) @(posedge clk_i);
    s_axi_bready <= 1'b1;
    @(posedge clk_i);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, r}, {30'h0, s_axi_bresp});
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    @(posedge clk_i);
    while (!s_axi_arready) @(posedge clk_i);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge clk_i);
    s_axi_rready <= 1'b1;
    @(posedge clk_i);
    s_axi_rready <= 1'b0;
    chk("rdata", e, s_axi_rdata);
    chk("rresp", {30'h0, r}, {30'h0, s_axi_rresp});
  endtask : rd

  task automatic take(input logic [15:0] e);
    @(posedge clk_i);
    while (!(cpu_ack_i && irq_req_o)) @(posedge clk_i);
    chk("vector", {16'h0, e}, {16'h0, vector_addr_o});
  endtask : take

  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    repeat (5) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    chk("irq_req", 32'h0, {31'h0, irq_req_o});
    rd(vic_pkg::ADDR_REQUEST, 32'h0, vic_pkg::RESP_OKAY);
    rd(vic_pkg::ADDR_ENABLE, 32'h0, vic_pkg::RESP_OKAY);
    rd(vic_pkg::ADDR_MASTER, 32'h0, vic_pkg::RESP_OKAY);
    rd(8'h20, 32'h0, vic_pkg::RESP_SLVERR);
    wr(8'h20, 32'h0, vic_pkg::RESP_SLVERR);
    dual_edge_ext_i   <= 1'b1;
    select_edge_ext_i <= 1'b1;
    ext_test_pin_i    <= 1'b1;
    watch_half_sec_i  <= 1'b1;
    tick(1);
    watch_half_sec_i  <= 1'b0;
    tick(3);
    rd(vic_pkg::ADDR_REQUEST, 32'hC2, vic_pkg::RESP_OKAY);
    wr(vic_pkg::ADDR_REQUEST, 32'h0);
    dual_edge_ext_i     <= 1'b0;
    select_edge_ext_i   <= 1'b0;
    ext_test_pin_i      <= 1'b0;
    key_return_inputs_i <= 8'hF7;
    tick(4);
    rd(vic_pkg::ADDR_REQUEST, 32'h46, vic_pkg::RESP_OKAY);
    wr(vic_pkg::ADDR_REQUEST, 32'h0);
    wr(vic_pkg::ADDR_EDGESEL, 32'h1);
    select_edge_ext_i <= 1'b1;
    interval_tick_i   <= 1'b1;
    second_ext_i      <= 1'b1;
    serial_done_i     <= 1'b1;
    timer_count_i     <= 8'h10;
    tick(1);
    interval_tick_i   <= 1'b0;
    second_ext_i      <= 1'b0;
    serial_done_i     <= 1'b0;
    tick(3);
    rd(vic_pkg::ADDR_REQUEST, 32'h3D, vic_pkg::RESP_OKAY);
    wr(vic_pkg::ADDR_ENABLE, 32'h3C);
    tick(3);
    chk("irq_req", 32'h0, {31'h0, irq_req_o});
    chk("standby", 32'h1, {31'h0, standby_release_o});
    wr(vic_pkg::ADDR_VECTOR, 32'h0100);
    wr(vic_pkg::ADDR_MASTER, 32'h1);
    cpu_slow <= 1'b1;
    cpu_go   <= 1'b1;
    foreach (exp_vec[i]) take(exp_vec[i]);
    cpu_go <= 1'b0;
    tick(3);
    rd(vic_pkg::ADDR_REQUEST, 32'h01, vic_pkg::RESP_OKAY);
    rd(vic_pkg::ADDR_MASTER, 32'h1, vic_pkg::RESP_OKAY);
    wr(vic_pkg::ADDR_ENABLE, 32'h03);
    cpu_slow <= 1'b0;
    cpu_go   <= 1'b1;
    take(16'h0102);
    cpu_go <= 1'b0;
    tick(3);
    rd(vic_pkg::ADDR_REQUEST, 32'h01, vic_pkg::RESP_OKAY);
    wr(vic_pkg::ADDR_REQUEST, 32'hFE);
    rd(vic_pkg::ADDR_REQUEST, 32'h0, vic_pkg::RESP_OKAY);
    wr(vic_pkg::ADDR_ENABLE, 32'hC0);
    rd(vic_pkg::ADDR_IRQSTAT, 32'h3, vic_pkg::RESP_OKAY);
    wr(vic_pkg::ADDR_IRQMASK, 32'h1);
    watch_half_sec_i <= 1'b1;
    tick(1);
    watch_half_sec_i <= 1'b0;
    tick(3);
    chk("irq", 32'h1, {31'h0, irq_o});
    chk("standby", 32'h1, {31'h0, standby_release_o});
    chk("irq_req", 32'h0, {31'h0, irq_req_o});
    rd(vic_pkg::ADDR_IRQSTAT, 32'h1, vic_pkg::RESP_OKAY);
    chk("irq", 32'h0, {31'h0, irq_o});
    wr(vic_pkg::ADDR_IRQMASK, 32'h0);
    key_return_inputs_i <= 8'hD7;
    tick(3);
    chk("irq", 32'h0, {31'h0, irq_o});
    rd(vic_pkg::ADDR_REQUEST, 32'hC0, vic_pkg::RESP_OKAY);
    complete_run();
  end

  initial
  begin
    #300000;
    n_mismatch++;
    complete_run();
  end
endmodule : vic_top_tb

bind vic_top vic_top_asserts i_chk (.clk_i, .nrst_i, .cpu_ack_i, .irq_req_o,
  .standby_release_o, .irq_o, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready);
